// file: instr_decode_sequencer.v
// instruction decode, control code register and sequence counter
`timescale 1ns/10ps
`default_nettype none
`include "instr_decode_map.vh"
module instr_decode_sequencer (
  input wire clk_sys,
  input wire reset_n,
  input wire shift_clk,
  input wire word_strobe,
  input wire serial_in,
  input wire skip_taken,
  input wire page_select_data,
  output reg [11:0] instr_buffer_reg,
  output reg [11:0] instr_shift_reg,
  output wire [5:0] op_field,
  output wire [5:0] reg_field,
  output wire [3:0] op_group_field,
  output wire mem_ref,
  output wire two_word,
  output wire acc_select,
  output wire modify_instr,
  output wire jump_to_register,
  output wire input_instr,
  output wire skip_instr,
  output wire shift_instr,
  output wire set_page_instr,
  output wire [1:0] shift_amount,
  output wire shift_left,
  output wire [2:0] shift_type,
  output wire [5:0] skip_condition,
  output reg [3:0] data_page_reg,
  output reg [3:0] program_page_reg,
  output reg [1:0] seq_state,
  output wire seq_stage_low,
  output wire seq_stage_high,
  output wire copy_next_instr,
  output reg [1:0] ctl_code,
  output reg reg_bus_code,
  output reg data_bus_code,
  output reg prog_bus_code,
  output wire pages_equal
);
  // timing: pin clocks are sampled as levels, so every action lags its pin
  // edge by three cycles; each pin level must last at least four cycles
  // synchroniser stages and edge history
  reg [1:0] sync_sc;
  reg [1:0] sync_ws;
  reg [1:0] sync_sd;
  reg [1:0] sync_sk;
  reg sc_prev;
  reg ws_prev;
  // code emission state
  reg [1:0] sent;
  reg index_code;
  reg exec_window;
  reg next_reg_bit;
  reg next_data_bit;
  reg next_prog_bit;
  // pulses and the synchronised skip level
  wire sc_rise;
  wire ws_rise;
  wire skip_now;
  // next-instruction decode
  wire [5:0] nxt_op;
  wire nxt_index;
  wire nxt_in;
  wire nxt_out;
  wire nxt_quiet;
  wire code_first;
  wire code_second;
  wire [1:0] next_ctl;
  // end-of-instruction terms and counter inputs
  wire load_lit;
  wire add_lit;
  wire exec_ends_single;
  wire term_index;
  wire term_exec;
  wire term_nop1;
  wire term_nop2;
  wire [1:0] next_restart_seq;
  wire [1:0] next_step_seq;
  wire [1:0] next_seq;

  // two-stage synchronisers for the pins; nothing reads the first stage
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      sync_sc <= 2'b00;
      sync_ws <= 2'b00;
      sync_sd <= 2'b00;
      sync_sk <= 2'b00;
    end else begin
      sync_sc <= {sync_sc[0], shift_clk};
      sync_ws <= {sync_ws[0], word_strobe};
      sync_sd <= {sync_sd[0], serial_in};
      sync_sk <= {sync_sk[0], skip_taken};
    end
  end

  // previous levels for edge detection; both clocks idle low after reset
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      sc_prev <= 1'b0;
      ws_prev <= 1'b0;
    end else begin
      sc_prev <= sync_sc[1];
      ws_prev <= sync_ws[1];
    end
  end

  // one-cycle pulses on the rising edge of each synchronised clock
  assign sc_rise = sync_sc[1] & ~sc_prev;
  assign ws_rise = sync_ws[1] & ~ws_prev;
  // skip test level, already synchronised
  assign skip_now = sync_sk[1];

  // field split of the current instruction
  assign op_field = instr_buffer_reg[`OP_MSB:`OP_LSB];
  assign reg_field = instr_buffer_reg[`REG_MSB:`REG_LSB];
  assign op_group_field = instr_buffer_reg[`GRP_MSB:`GRP_LSB];
  assign acc_select = instr_buffer_reg[`ACC_BIT];
  // exception decodes
  // modify and register jump carry the memory flag but are one word
  assign modify_instr = (op_field == `OPC_MODIFY);
  assign jump_to_register = (op_field == `OPC_JUMPREG);
  // input takes a mask word; skip and shift read the register field
  assign input_instr = (op_field == `OPC_INPUT);
  assign skip_instr = (op_field == `OPC_SKIP);
  assign shift_instr = (op_field == `OPC_SHIFT);
  // set-page ignores the accumulator flag, which picks the page register
  assign set_page_instr = ({op_field[5:1], 1'b0} == `OPC_SETPAGE);
  // literal instructions end in execute without waiting on memory
  assign load_lit = (op_field == `OPC_LOADLIT);
  assign add_lit = (op_field == `OPC_ADDLIT);
  // memory flag, with modify and register-jump excluded
  assign mem_ref = instr_buffer_reg[`MEM_BIT] & ~modify_instr
    & ~jump_to_register;
  // address or mask word follows
  assign two_word = mem_ref | input_instr;
  // shift subfields: amount in the low bits, then direction, then kind
  assign shift_amount = shift_instr ? reg_field[1:0] : 2'b00;
  assign shift_left = shift_instr & reg_field[2];
  assign shift_type = shift_instr ? reg_field[5:3] : 3'b000;
  // skip: the whole register field names the test; zero otherwise
  assign skip_condition = skip_instr ? reg_field : 6'b000000;

  // memory selection comparator
  assign pages_equal = (data_page_reg == program_page_reg);

  // decode of the next instruction waiting in the shift register
  assign nxt_op = instr_shift_reg[`OP_MSB:`OP_LSB];
  // bit 7 of the waiting word asks for an index cycle first
  assign nxt_index = instr_shift_reg[`MEM_BIT];
  assign nxt_in = (nxt_op == `OPC_INPUT);
  assign nxt_out = (nxt_op == `OPC_OUTPUT);
  // instructions that leave the register unshifted
  assign nxt_quiet = (nxt_op == `OPC_NOP) | (nxt_op == `OPC_SHIFT)
    | (nxt_op == `OPC_SKIP) | nxt_in;
  // first code bit: input and output only; second: all but the quiet ones
  assign code_first = nxt_in | nxt_out;
  assign code_second = ~nxt_quiet;
  // an indexed instruction asks for a memory read first
  assign next_ctl = nxt_index ? `CC_READ
    : {code_second, code_first};

  // end-of-instruction detection
  assign seq_stage_low = seq_state[0];
  assign seq_stage_high = seq_state[1];
  // modify finishes with its index cycle
  assign term_index = (seq_state == `SEQ_INDEX) & modify_instr;
  // single-cycle work ends in execute unless a taken skip holds it
  assign exec_ends_single = ~instr_buffer_reg[`MEM_BIT]
    & ~(skip_instr & skip_now);
  // execute ends on split memories, register jump, literals or one cycle
  assign term_exec = (seq_state == `SEQ_EXEC)
    & (~pages_equal
    | jump_to_register | load_lit | add_lit
    | exec_ends_single);
  // shared memory: no write-back means the first no-op is the last
  assign term_nop1 = (seq_state == `SEQ_NOP1) & pages_equal
    & ~instr_buffer_reg[`WB_BIT];
  // the last state always ends, so no instruction exceeds four cycles
  assign term_nop2 = (seq_state == `SEQ_NOP2);
  // any end condition copies the next instruction in
  assign copy_next_instr = term_index | term_exec | term_nop1 | term_nop2;

  // restart at index for a memory instruction, otherwise at execute
  assign next_restart_seq = nxt_index ? `SEQ_INDEX : `SEQ_EXEC;
  // free step: low stage takes high stage, high takes inverted low
  assign next_step_seq = {~seq_state[0], seq_state[1]};
  // end of instruction restarts the counter, otherwise it steps
  assign next_seq = copy_next_instr ? next_restart_seq : next_step_seq;

  // word strobe steps the counter and loads the buffer and code register
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      instr_buffer_reg <= `WORD_RESET;
      seq_state <= `SEQ_RESET;
      ctl_code <= `CC_RESET;
      index_code <= 1'b0;
      exec_window <= 1'b0;
    end else if (ws_rise) begin
      seq_state <= next_seq;
      // program bus code follows the state this strobe enters
      exec_window <= (next_seq == `SEQ_EXEC);
      if (copy_next_instr) begin
        instr_buffer_reg <= instr_shift_reg;
        ctl_code <= next_ctl;
        index_code <= nxt_index;
      end else begin
        // a cycle with no new instruction leaves the register and data buses idle
        ctl_code <= `CC_NOP;
        index_code <= 1'b0;
      end
    end
  end

  // set-page writes the register field in execute; the flag picks the page
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      data_page_reg <= `PAGE_RESET;
      program_page_reg <= `PAGE_RESET;
    end else if (ws_rise & set_page_instr & (seq_state == `SEQ_EXEC)) begin
      if (acc_select) begin
        program_page_reg <= reg_field[3:0];
      end else begin
        data_page_reg <= reg_field[3:0];
      end
    end
  end

  // serial input: one instruction bit per shift clock, low bit first
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      instr_shift_reg <= `WORD_RESET;
    end else if (sc_rise) begin
      instr_shift_reg <= {sync_sd[1], instr_shift_reg[11:1]};
    end
  end

  // code bits for the slot being sent; silent once both slots are out
  always @* begin
    next_reg_bit = 1'b0;
    next_data_bit = 1'b0;
    next_prog_bit = 1'b0;
    if (sent != 2'b10) begin
      if (sent == 2'b00) begin
        // first (low) bit goes first; index blocks it on the register bus
        next_reg_bit = ctl_code[0] & ~index_code;
        next_data_bit = ctl_code[0] & index_code;
      end else begin
        next_reg_bit = ctl_code[1];
        next_data_bit = ctl_code[1] & index_code;
      end
      // program memory reads unless it serves data during execute
      next_prog_bit = ~(exec_window & pages_equal);
    end
  end

  // code output: cleared on the word strobe, two bits on the shift clock
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      sent <= 2'b00;
      reg_bus_code <= 1'b0;
      data_bus_code <= 1'b0;
      prog_bus_code <= 1'b0;
    end else if (ws_rise) begin
      sent <= 2'b00;
      reg_bus_code <= 1'b0;
      data_bus_code <= 1'b0;
      prog_bus_code <= 1'b0;
    end else if (sc_rise) begin
      if (sent != 2'b10) begin
        sent <= sent + 2'b01;
      end
      // later shift edges carry zeros until the next strobe
      reg_bus_code <= next_reg_bit;
      data_bus_code <= next_data_bit;
      prog_bus_code <= next_prog_bit;
    end
  end
endmodule // instr_decode_sequencer
`default_nettype wire

// file: instr_decode_map.vh
// constants for the instruction decode and sequence block
`ifndef INSTR_DECODE_MAP_VH
`define INSTR_DECODE_MAP_VH
`define WORD_W 12
`define OP_MSB 11
`define OP_LSB 6
`define REG_MSB 5
`define REG_LSB 0
`define GRP_MSB 11
`define GRP_LSB 8
`define MEM_BIT 7
`define ACC_BIT 6
`define WB_BIT 8
`define CC_NOP 2'b00
`define CC_SHIFT 2'b10
`define CC_READ 2'b11
`define CC_WRITE 2'b01
`define SEQ_INDEX 2'b01
`define SEQ_EXEC 2'b00
`define SEQ_NOP1 2'b10
`define SEQ_NOP2 2'b11
`define SEQ_RESET 2'b00
`define CC_RESET 2'b00
`define WORD_RESET 12'h000
`define PAGE_RESET 4'h0
`define OPC_NOP 6'b000000
`define OPC_SKIP 6'b001000
`define OPC_SHIFT 6'b001100
`define OPC_SETPAGE 6'b000100
`define OPC_INPUT 6'b100000
`define OPC_OUTPUT 6'b100100
`define OPC_MODIFY 6'b101010
`define OPC_JUMPREG 6'b001111
`define OPC_LOADLIT 6'b101111
`define OPC_ADDLIT 6'b110011
`endif

// file: instr_decode_sequencer_chk.sv
// assertion checker for the decode and sequence block
`timescale 1ns/10ps
`default_nettype none
`include "instr_decode_map.vh"
module instr_decode_sequencer_chk (
  input wire clk_sys,
  input wire reset_n,
  input wire [11:0] instr_buffer_reg,
  input wire [5:0] op_field,
  input wire mem_ref,
  input wire two_word,
  input wire modify_instr,
  input wire [1:0] seq_state,
  input wire copy_next_instr,
  input wire [1:0] ctl_code,
  input wire pages_equal
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  // a new word reached the buffer, or the counter stepped on its own
  sequence s_load; $changed(instr_buffer_reg); endsequence
  sequence s_adv; $changed(seq_state) && !$past(copy_next_instr); endsequence
  // decode, termination and counter relations
  property p_fields;
    op_field == instr_buffer_reg[11:6]
      && mem_ref == (instr_buffer_reg[7] && !modify_instr
      && instr_buffer_reg[11:6] != `OPC_JUMPREG);
  endproperty
  a_fields: assert property (p_fields) else $error("field split");
  property p_mod; modify_instr |-> !two_word; endproperty
  a_mod: assert property (p_mod) else $error("modify is two words");
  property p_mdi; seq_state == `SEQ_INDEX && modify_instr |-> copy_next_instr;
  endproperty
  a_mdi: assert property (p_mdi) else $error("modify kept going");
  property p_last; seq_state == `SEQ_NOP2 |-> copy_next_instr; endproperty
  a_last: assert property (p_last) else $error("last state held");
  property p_diff; seq_state == `SEQ_EXEC && !pages_equal |-> copy_next_instr;
  endproperty
  a_diff: assert property (p_diff) else $error("execute held");
  property p_step;
    s_adv |-> seq_state == {~$past(seq_state[0]), $past(seq_state[1])};
  endproperty
  a_step: assert property (p_step) else $error("bad state order");
  property p_load;
    s_load |-> $past(copy_next_instr)
      && seq_state == {1'b0, instr_buffer_reg[7]};
  endproperty
  a_load: assert property (p_load) else $error("bad restart");
  property p_code; s_load ##0 instr_buffer_reg[7] |-> ctl_code == `CC_READ;
  endproperty
  a_code: assert property (p_code) else $error("index code wrong");
endmodule // instr_decode_sequencer_chk
bind instr_decode_sequencer
  instr_decode_sequencer_chk i_instr_decode_sequencer_chk (.clk_sys, .reset_n,
  .instr_buffer_reg, .op_field, .mem_ref, .two_word, .modify_instr,
  .seq_state, .copy_next_instr, .ctl_code, .pages_equal);
`default_nettype wire

// file: serial_mem_model.sv
// far side: memory feeding words serially and collecting bus codes
`timescale 1ns/10ps
`default_nettype none
module serial_mem_model (
  input wire logic shift_clk,
  input wire logic word_strobe,
  input wire logic [11:0] word,
  input wire logic reg_bus_code,
  input wire logic data_bus_code,
  input wire logic prog_bus_code,
  output var logic serial_in,
  output var logic [1:0] reg_code,
  output var logic [1:0] data_code,
  output var logic [1:0] prog_code
);
  logic [3:0] cnt = 4'h0;
  initial serial_in = 1'b0;
  // count shift pulses in the machine cycle
  always @(posedge shift_clk or posedge word_strobe) begin
    if (word_strobe) cnt <= 4'h0;
    else cnt <= cnt + 4'h1;
  end
  // data after the two code slots, lowest bit first; toggles when idle
  always @(negedge shift_clk) begin
    serial_in <= (cnt > 4'h1 && cnt < 4'he) ? word[cnt - 4'h2] : ~serial_in;
    if (cnt == 4'h1) {reg_code[0], data_code[0], prog_code[0]} <=
      {reg_bus_code, data_bus_code, prog_bus_code};
    if (cnt == 4'h2) {reg_code[1], data_code[1], prog_code[1]} <=
      {reg_bus_code, data_bus_code, prog_bus_code};
  end
endmodule // serial_mem_model
`default_nettype wire

// file: instr_decode_sequencer_test.sv
// self-checking bench for the decode and sequence block
`timescale 1ns/10ps
`default_nettype none
`include "instr_decode_map.vh"
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin \
  mismatches++; $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module instr_decode_sequencer_test;
  logic clk_sys = 1'b0, reset_n = 1'b0, shift_clk = 1'b0;
  logic word_strobe = 1'b0, skip_taken = 1'b0;
  logic [11:0] word = 12'h000;
  wire serial_in, two_word, modify_instr, shift_left, pages_equal;
  wire acc_select;
  wire [5:0] skip_condition;
  wire [3:0] op_group_field;
  wire reg_bus_code, data_bus_code, prog_bus_code;
  wire [11:0] instr_buffer_reg;
  wire [1:0] shift_amount, seq_state, ctl_code, reg_code, data_code, prog_code;
  wire [2:0] shift_type;
  wire [3:0] data_page_reg, program_page_reg;
  int mismatches = 0;
  int num_checks = 0;
  // design and far-side model; the reserved select pin stays low
  instr_decode_sequencer i_instr_decode_sequencer (.clk_sys, .reset_n,
    .shift_clk, .word_strobe, .serial_in, .skip_taken,
    .page_select_data(1'b0), .instr_buffer_reg, .instr_shift_reg(),
    .op_field(), .reg_field(), .op_group_field, .mem_ref(), .two_word,
    .acc_select, .modify_instr, .jump_to_register(), .input_instr(),
    .skip_instr(), .shift_instr(), .set_page_instr(), .shift_amount,
    .shift_left, .shift_type, .skip_condition, .data_page_reg,
    .program_page_reg, .seq_state, .seq_stage_low(), .seq_stage_high(),
    .copy_next_instr(), .ctl_code, .reg_bus_code, .data_bus_code,
    .prog_bus_code, .pages_equal);
  serial_mem_model i_serial_mem_model (.shift_clk, .word_strobe, .word,
    .reg_bus_code, .data_bus_code, .prog_bus_code, .serial_in, .reg_code,
    .data_code, .prog_code);
  always #5 clk_sys = ~clk_sys;
  task tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  // one shift pulse (s high) or one word strobe
  task pulse(input bit s);
    if (s) shift_clk = 1'b1;
    else word_strobe = 1'b1;
    tick(8);
    shift_clk = 1'b0;
    word_strobe = 1'b0;
    tick(8);
  endtask
  // machine cycle carrying w, then the new sequence state
  task step(input logic [11:0] w, input logic [1:0] s);
    word = w;
    repeat (14) pulse(1'b1);
    pulse(1'b0);
    `CHK("seq_state", s, seq_state)
  endtask
  task t_index;
    step({`OPC_MODIFY, 6'h05}, `SEQ_INDEX);
    `CHK("code", `CC_READ, ctl_code)
    `CHK("two_word", 1'b0, two_word)
    step(12'h000, `SEQ_EXEC);
    `CHK("reg_bus", `CC_SHIFT, reg_code)
    `CHK("data_bus", `CC_READ, data_code)
    $display("index test done");
  endtask
  task t_codes;
    logic [5:0] ops [5] = '{`OPC_OUTPUT, `OPC_INPUT, `OPC_SHIFT, `OPC_SKIP,
      6'b110000};
    logic [1:0] cc [5] = '{`CC_READ, `CC_WRITE, `CC_NOP, `CC_NOP, `CC_SHIFT};
    for (int i = 0; i < 5; i++) begin
      step({ops[i], 6'h2e}, `SEQ_EXEC);
      `CHK("code", cc[i], ctl_code)
      `CHK("two_word", ops[i] == `OPC_INPUT, two_word)
      if (i == 2)
        `CHK("shift", 6'h2e, {shift_type, shift_left, shift_amount})
      if (i == 3) `CHK("skip_cond", 6'h2e, skip_condition)
    end
    $display("code test done");
  endtask
  task t_long;
    step(12'h180, `SEQ_INDEX);
    step(12'h000, `SEQ_EXEC);
    `CHK("prog_bus", `CC_READ, prog_code)
    step(12'h000, `SEQ_NOP1);
    `CHK("prog_bus", `CC_NOP, prog_code)
    step(12'h000, `SEQ_NOP2);
    step(12'h000, `SEQ_EXEC);
    `CHK("buffer", 12'h000, instr_buffer_reg)
    $display("long test done");
  endtask
  task t_skip;
    step({`OPC_SKIP, 6'h01}, `SEQ_EXEC);
    skip_taken = 1'b1;
    step(12'h000, `SEQ_NOP1);
    skip_taken = 1'b0;
    step({`OPC_LOADLIT, 6'h03}, `SEQ_INDEX);
    step({`OPC_MODIFY, 6'h01}, `SEQ_EXEC);
    step({`OPC_MODIFY, 6'h01}, `SEQ_INDEX);
    step(12'h000, `SEQ_EXEC);
    $display("skip test done");
  endtask
  task t_page;
    step({`OPC_SETPAGE, 6'h05}, `SEQ_EXEC);
    `CHK("group", 4'h1, op_group_field)
    `CHK("acc", 1'b0, acc_select)
    step(12'h180, `SEQ_INDEX);
    `CHK("data_page", 4'h5, data_page_reg)
    step(12'h000, `SEQ_EXEC);
    step(12'h145, `SEQ_EXEC);
    `CHK("acc", 1'b1, acc_select)
    step(12'h000, `SEQ_EXEC);
    `CHK("prog_page", 4'h5, program_page_reg)
    `CHK("equal", 1'b1, pages_equal)
    $display("page test done");
  endtask
  task final_report;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // reset, every scenario, verdict
  initial begin
    tick(6);
    reset_n = 1'b1;
    tick(2);
    t_index();
    t_codes();
    t_long();
    t_skip();
    t_page();
    final_report();
  end
endmodule // instr_decode_sequencer_test
`default_nettype wire
